// >>> bench/echo_stop_pulse_manager_test.sv
`timescale 1ns/1ps
module echo_stop_pulse_manager_test;
  // ==========================================
  // signals
  logic       clk, rst, bypass, bufOff, rtdSel, divSel, multi, rxStart, rxEnd, above, below, thrPass;
  logic       ampEn, ampRoute, bufEn, rtd500, cancelOn, tempClk, arrival;
  logic [2:0] gain, thresh, divCode, gainSel;
  logic [3:0] limit, arrivalCount;
  logic [7:0] cancelLen, dacSel, pulsesSeen;
  int         failCount = 0;
  int         testsRun = 0;

  // ==========================================
  // design and far-side timer
  echo_stop_pulse_manager #(.LIMIT_W(4), .CANCEL_W(8)) dut (
    .clk(clk), .rst(rst), .ampGainCode(gain), .ampBypass(bypass), .offsetCancelLength(cancelLen),
    .echoThresholdCode(thresh), .midrailBufferOff(bufOff), .rtdTypeSelect(rtdSel),
    .burstDividerCode(divCode), .tempDivSelect(divSel), .echoReceiveSelect(multi),
    .stopPulseLimit(limit), .rxStart(rxStart), .rxEnd(rxEnd), .crossAboveRef(above),
    .crossBelowHyst(below), .thresholdPassed(thrPass), .ampGainSel(gainSel), .ampEnable(ampEn),
    .ampRouteAround(ampRoute), .thresholdDacSel(dacSel), .midrailBufferEnable(bufEn),
    .rtd500Select(rtd500), .offsetCancelActive(cancelOn), .tempClock(tempClk),
    .arrivalOut(arrival), .arrivalCount(arrivalCount));
  echo_stop_receiver_model timer (.clk(clk), .rst(rst), .clear(rxStart), .arrivalOut(arrival),
    .pulsesSeen(pulsesSeen));

  // ==========================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #200us;
    failCount++;
    $display("Error at %0t: watchdog expired", $time);
    tallyAndFinish();
  end

  // ==========================================
  // helpers and compares
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string what);
    testsRun++;
    if (got !== exp) begin
      failCount++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic check_len(input int got, input int exp, input string what);
    testsRun++;
    if (got != exp) begin
      failCount++;
      $display("Error at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask
  task automatic tallyAndFinish();
    $display("Counts: %0d compares, %0d mismatches", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one echo period, with a re-rise inside the hysteresis band before the real fall
  task automatic drive_cross(input logic qualify);
    @(posedge clk) thrPass <= qualify;
    @(posedge clk) thrPass <= 1'b0;
    @(posedge clk) above <= 1'b1;
    tick(3);
    @(posedge clk) above <= 1'b0;
    tick(3);
    @(posedge clk) above <= 1'b1;
    tick(3);
    @(posedge clk) above <= 1'b0;
    @(posedge clk) below <= 1'b1;
    tick(3);
    @(posedge clk) below <= 1'b0;
    tick(3);
  endtask

  // whole receive cycle: start, cancel interval, crossings, end
  task automatic receive(input logic mode, input logic [3:0] lim, input int n, input logic each,
                         input logic first, input logic [7:0] exp);
    int len;
    int waitCnt;
    len = 0;
    waitCnt = 0;
    @(posedge clk) begin
      multi <= mode;
      limit <= lim;
      rxStart <= 1'b1;
    end
    @(posedge clk) rxStart <= 1'b0;
    while (cancelOn !== 1'b1 && waitCnt < 10) begin
      tick(1);
      waitCnt++;
    end
    while (cancelOn === 1'b1 && len < 300) begin
      tick(1);
      len++;
    end
    check_len(len, int'(cancelLen) + 1, "cancel length");
    check_val({4'h0, arrivalCount}, 8'h00, "count at cycle start");
    for (int i = 0; i < n; i++) begin
      drive_cross(each || (first && i == 0));
    end
    @(posedge clk) rxEnd <= 1'b1;
    @(posedge clk) rxEnd <= 1'b0;
    tick(2);
    check_val(pulsesSeen, exp, "pulses timed");
    check_val({4'h0, arrivalCount}, exp, "pulse count");
  endtask

  // temperature clock half period in clk cycles
  task automatic temp_period(input logic sel, input logic [2:0] code, input int half);
    logic v;
    int   n;
    n = 0;
    @(posedge clk) begin
      divSel <= sel;
      divCode <= code;
    end
    tick(40);
    v = tempClk;
    while (tempClk === v && n < 300) begin
      tick(1);
      n++;
    end
    v = tempClk;
    n = 0;
    while (tempClk === v && n < 300) begin
      tick(1);
      n++;
    end
    check_len(n, half, "temp clock half period");
  endtask

  // ==========================================
  // test sequence
  initial begin
    {bypass, bufOff, rtdSel, divSel, multi, rxStart, rxEnd, above, below, thrPass} = 10'h000;
    {gain, thresh, divCode} = 9'h000;
    limit = 4'h2;
    cancelLen = 8'h02;
    rst = 1'b1;
    tick(19);
    check_val(dacSel, 8'h01, "reset threshold");
    check_val({4'h0, arrivalCount}, 8'h00, "reset count");
    @(posedge clk) rst <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      @(posedge clk) begin
        gain <= c[2:0];
        thresh <= c[2:0];
        bypass <= c[0];
        bufOff <= c[1];
        rtdSel <= c[2];
      end
      tick(3);
      check_val({5'h00, gainSel}, c[7:0], "gain select");
      check_val(dacSel, 8'h01 << c, "threshold level");
      check_val({6'h00, ampEn, ampRoute}, {6'h00, ~c[0], c[0]}, "amp bypass");
      check_val({6'h00, bufEn, rtd500}, {6'h00, ~c[1], c[2]}, "buffer and rtd");
    end
    $display("config test done");
    temp_period(1'b0, 3'h3, 4);
    temp_period(1'b1, 3'h1, 2);
    temp_period(1'b1, 3'h7, 128);
    $display("temperature clock test done");
    receive(1'b0, 4'h2, 3, 1'b1, 1'b1, 8'h02);
    receive(1'b0, 4'h4, 3, 1'b0, 1'b1, 8'h01);
    @(posedge clk) cancelLen <= 8'h00;
    receive(1'b1, 4'h4, 2, 1'b0, 1'b1, 8'h02);
    receive(1'b1, 4'h3, 5, 1'b0, 1'b1, 8'h03);
    receive(1'b1, 4'h4, 1, 1'b0, 1'b0, 8'h00);
    $display("receive test done");
    tallyAndFinish();
  end
endmodule

// >>> bench/echo_stop_receiver_model.sv
`timescale 1ns/1ps
// ==========================================
// stop-pulse timer on the far side of the arrival pin
module echo_stop_receiver_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // measurement start and stop pulses
  input  wire logic       clear,
  input  wire logic       arrivalOut,
  // stop events timed so far
  output logic      [7:0] pulsesSeen
);
  // one stop event per high cycle, so a stretched pulse shows as extra events
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulsesSeen <= 8'h00;
    end else if (clear) begin
      pulsesSeen <= 8'h00;
    end else if (arrivalOut) begin
      pulsesSeen <= pulsesSeen + 8'h01;
    end
  end
endmodule

// >>> verilog/echo_event_if.sv
`timescale 1ns/1ps
// ==========================================
// event manager carrier between sequencer and pulse logic
interface echo_event_if #(parameter int LIMIT_W = 4);
  logic               cycleStart;
  logic               echoActive;
  logic               crossRise;
  logic               thresholdHit;
  logic               multiEcho;
  logic [LIMIT_W-1:0] pulseLimit;
  logic               arrivalPulse;
  logic [LIMIT_W-1:0] pulseCount;
  logic               qualified;
  modport ctrl (output cycleStart, echoActive, crossRise, thresholdHit, multiEcho, pulseLimit,
                input arrivalPulse, pulseCount, qualified);
  modport mgr  (input cycleStart, echoActive, crossRise, thresholdHit, multiEcho, pulseLimit,
                output arrivalPulse, pulseCount, qualified);
endinterface

// >>> verilog/echo_event_manager.sv
`timescale 1ns/1ps
// ==========================================
// qualifies zero-crossings and limits arrival pulses
module echo_event_manager #(
  parameter int LIMIT_W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // carrier
  echo_event_if.mgr ev
);
  logic               qual_reg;
  logic               qual_next;
  logic [LIMIT_W-1:0] count_reg;
  logic [LIMIT_W-1:0] count_next;
  logic               pulse_reg;
  logic               pulse_next;
  wire                belowLimit = count_reg < ev.pulseLimit;
  wire                fire       = ev.echoActive && ev.crossRise && qual_reg && belowLimit;

  // qualification: set on threshold, consumed by a forwarded crossing in single-echo mode only
  assign qual_next  = ev.cycleStart ? 1'b0 :                               // [RULE16]
                      (ev.echoActive && ev.thresholdHit) ? 1'b1 :          // [RULE7]
                      (fire && !ev.multiEcho) ? 1'b0 : qual_reg;           // [RULE9] [RULE10]
  // pulse count up to the limit
  assign count_next = ev.cycleStart ? '0 : fire ? count_reg + 1'b1 : count_reg; // [RULE16] [RULE8]
  assign pulse_next = fire;                                                // [RULE8]

  // state registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      qual_reg  <= 1'b0;
      count_reg <= '0;
      pulse_reg <= 1'b0;
    end else begin
      qual_reg  <= qual_next;
      count_reg <= count_next;
      pulse_reg <= pulse_next;
    end
  end

  assign ev.arrivalPulse = pulse_reg;
  assign ev.pulseCount   = count_reg;
  assign ev.qualified    = qual_reg;

  // no pulse beyond the limit
  property p_limit;
    @(posedge clk) disable iff (rst) pulse_reg |-> count_reg <= ev.pulseLimit;
  endproperty
  a_limit: assert property (p_limit) else $error("pulse count over limit"); // [RULE8]

  // cycle start clears state
  property p_clear;
    @(posedge clk) disable iff (rst) ev.cycleStart |=> (count_reg == '0 && !qual_reg);
  endproperty
  a_clear: assert property (p_clear) else $error("cycle start did not clear"); // [RULE16]

  // pulse only after qualified crossing
  property p_qualified;
    @(posedge clk) disable iff (rst) pulse_reg |-> $past(qual_reg) && $past(ev.crossRise);
  endproperty
  a_qualified: assert property (p_qualified) else $error("unqualified pulse"); // [RULE7]

  // single echo consumes qualification
  property p_single;
    @(posedge clk) disable iff (rst)
      (fire && !ev.multiEcho && !ev.thresholdHit && !ev.cycleStart) |=> !qual_reg;
  endproperty
  a_single: assert property (p_single) else $error("qualification not consumed"); // [RULE10]
endmodule

// >>> verilog/echo_stop_pkg.sv
package echo_stop_pkg;
  // ==========================================
  // widths
  localparam int GAIN_W      = 3;
  localparam int THRESH_W    = 3;
  localparam int LIMIT_W     = 4;
  localparam int CANCEL_W    = 8;
  localparam int DIV_W       = 3;
  localparam int TDIV_W      = 8;
  // ==========================================
  // reset values
  localparam logic [2:0] GAIN_RESET   = 3'h0;
  localparam logic [2:0] THRESH_RESET = 3'h0;
  // ==========================================
  // gain step in dB per code
  localparam int GAIN_STEP_DB = 3;
  // fixed temperature clock divide
  localparam int TEMP_FIXED_DIV = 8;
  // pipeline depth of the zero-cross edge detector
  localparam int EDGE_DEPTH = 2;
  // ==========================================
  // receive cycle sequencer states
  typedef enum logic [2:0] {
    IDLE_ST   = 3'b001,
    CANCEL_ST = 3'b010,
    ECHO_ST   = 3'b100
  } rx_state_type;
endpackage

// >>> verilog/echo_stop_pulse_manager.sv
`timescale 1ns/1ps
// Behaviour
// RULE1 - three-bit code sets gain, 3 dB steps
// RULE2 - bypass bit disables and routes around amplifier
// RULE3 - offset cancel interval starts every receive cycle
// RULE4 - cancel length from configurable duration field
// RULE5 - threshold code selects one of eight levels
// RULE6 - zero-cross output with negative hysteresis
// RULE7 - threshold pass qualifies next zero-cross
// RULE8 - forward qualified crossings up to limit
// RULE9 - one select bit picks pulse behaviour
// RULE10 - select zero means single-echo mode
// RULE11 - buffer off bit disables midrail reference buffer
// RULE12 - host sets RTD type before temperature run
// RULE13 - select one is 500 ohm, zero 1000
// RULE14 - temperature clock divided by 8 or burst divider
// RULE15 - host keeps temperature clock at 1 MHz or below
// RULE16 - clear count and qualification each cycle
module echo_stop_pulse_manager #(
  parameter int LIMIT_W  = echo_stop_pkg::LIMIT_W,
  parameter int CANCEL_W = echo_stop_pkg::CANCEL_W
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // configuration
  input  wire logic [2:0]          ampGainCode,
  input  wire logic                ampBypass,
  input  wire logic [CANCEL_W-1:0] offsetCancelLength,
  input  wire logic [2:0]          echoThresholdCode,
  input  wire logic                midrailBufferOff,
  input  wire logic                rtdTypeSelect,
  input  wire logic [2:0]          burstDividerCode,
  input  wire logic                tempDivSelect,
  input  wire logic                echoReceiveSelect,
  input  wire logic [LIMIT_W-1:0]  stopPulseLimit,
  // receive cycle control
  input  wire logic                rxStart,
  input  wire logic                rxEnd,
  // comparator inputs
  input  wire logic                crossAboveRef,
  input  wire logic                crossBelowHyst,
  input  wire logic                thresholdPassed,
  // analog controls
  output logic [2:0]               ampGainSel,
  output logic                     ampEnable,
  output logic                     ampRouteAround,
  output logic [7:0]               thresholdDacSel,
  output logic                     midrailBufferEnable,
  output logic                     rtd500Select,
  output logic                     offsetCancelActive,
  output logic                     tempClock,
  // arrival pulses
  output logic                     arrivalOut,
  output logic [LIMIT_W-1:0]       arrivalCount
);
  // ==========================================
  // static decode of configuration
  wire [7:0] dacOneHot = 8'h01 << echoThresholdCode;                     // [RULE5]

  // analog control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ampGainSel          <= echo_stop_pkg::GAIN_RESET;
      ampEnable           <= 1'b0;
      ampRouteAround      <= 1'b0;
      thresholdDacSel     <= 8'h01;
      midrailBufferEnable <= 1'b0;
      rtd500Select        <= 1'b0;
    end else begin
      ampGainSel          <= ampGainCode;                                // [RULE1]
      ampEnable           <= !ampBypass;                                 // [RULE2]
      ampRouteAround      <= ampBypass;                                  // [RULE2]
      thresholdDacSel     <= dacOneHot;                                  // [RULE5]
      midrailBufferEnable <= !midrailBufferOff;                          // [RULE11]
      rtd500Select        <= rtdTypeSelect;                              // [RULE13] [RULE12]
    end
  end

  // ==========================================
  // receive cycle sequencer
  echo_stop_pkg::rx_state_type state_reg;
  echo_stop_pkg::rx_state_type state_next;
  logic [CANCEL_W-1:0]         cancel_reg;
  logic [CANCEL_W-1:0]         cancel_next;
  wire                         cancelDone = cancel_reg == '0;

  always_comb begin
    state_next  = state_reg;
    cancel_next = cancel_reg;
    case (state_reg)
      echo_stop_pkg::IDLE_ST: begin
        if (rxStart) begin
          state_next  = echo_stop_pkg::CANCEL_ST;                        // [RULE3]
          cancel_next = offsetCancelLength;                              // [RULE4]
        end
      end
      echo_stop_pkg::CANCEL_ST: begin
        if (cancelDone) begin
          state_next = echo_stop_pkg::ECHO_ST;
        end else begin
          cancel_next = cancel_reg - 1'b1;                               // [RULE4]
        end
      end
      echo_stop_pkg::ECHO_ST: begin
        if (rxEnd) begin
          state_next = echo_stop_pkg::IDLE_ST;
        end
      end
      default: begin
        state_next = echo_stop_pkg::IDLE_ST;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg          <= echo_stop_pkg::IDLE_ST;
      cancel_reg         <= '0;
      offsetCancelActive <= 1'b0;
    end else begin
      state_reg          <= state_next;
      cancel_reg         <= cancel_next;
      offsetCancelActive <= state_next == echo_stop_pkg::CANCEL_ST;     // [RULE3]
    end
  end

  // ==========================================
  // zero-cross detector with negative hysteresis
  logic zeroCross_reg;
  logic zeroCrossDly_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zeroCross_reg    <= 1'b0;
      zeroCrossDly_reg <= 1'b0;
    end else begin
      if (crossAboveRef) begin
        zeroCross_reg <= 1'b1;                                           // [RULE6]
      end else if (crossBelowHyst) begin
        zeroCross_reg <= 1'b0;                                           // [RULE6]
      end
      zeroCrossDly_reg <= zeroCross_reg;
    end
  end
  wire crossRise = zeroCross_reg && !zeroCrossDly_reg;

  // ==========================================
  // event manager
  echo_event_if #(.LIMIT_W(LIMIT_W)) ev ();
  assign ev.cycleStart   = rxStart && state_reg == echo_stop_pkg::IDLE_ST;  // [RULE16]
  assign ev.echoActive   = state_reg == echo_stop_pkg::ECHO_ST;            // [RULE3]
  assign ev.crossRise    = crossRise;
  assign ev.thresholdHit = thresholdPassed;
  assign ev.multiEcho    = echoReceiveSelect;                              // [RULE9]
  assign ev.pulseLimit   = stopPulseLimit;

  echo_event_manager #(.LIMIT_W(LIMIT_W)) manager (
    .clk (clk),
    .rst (rst),
    .ev  (ev)
  );

  // arrival output registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arrivalOut   <= 1'b0;
      arrivalCount <= '0;
    end else begin
      arrivalOut   <= ev.arrivalPulse;                                   // [RULE8]
      arrivalCount <= ev.pulseCount;
    end
  end

  // ==========================================
  // temperature clock divider: fixed 8 or 2^(code+1)
  logic [echo_stop_pkg::TDIV_W-1:0] tdiv_reg;
  wire  [echo_stop_pkg::TDIV_W-1:0] halfFixed = 8'(echo_stop_pkg::TEMP_FIXED_DIV / 2);
  wire  [echo_stop_pkg::TDIV_W-1:0] halfBurst = 8'h01 << burstDividerCode;
  wire  [echo_stop_pkg::TDIV_W-1:0] halfSel   = tempDivSelect ? halfBurst : halfFixed; // [RULE14] [RULE15]
  wire                              tdivWrap  = tdiv_reg >= halfSel - 1'b1;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tdiv_reg  <= '0;
      tempClock <= 1'b0;
    end else begin
      tdiv_reg  <= tdivWrap ? '0 : tdiv_reg + 1'b1;                      // [RULE14]
      tempClock <= tdivWrap ? !tempClock : tempClock;                    // [RULE14]
    end
  end

  // ==========================================
  // checks
  sequence s_start;
    state_reg == echo_stop_pkg::IDLE_ST && rxStart;
  endsequence
  sequence s_cancel;
    state_reg == echo_stop_pkg::CANCEL_ST;
  endsequence

  property p_cancel_first;
    @(posedge clk) disable iff (rst) s_start |=> s_cancel;
  endproperty
  a_cancel_first: assert property (p_cancel_first) else $error("no cancel interval"); // [RULE3]

  property p_cancel_len;
    @(posedge clk) disable iff (rst)
      (s_start and offsetCancelLength == 8'h02) |=> s_cancel [*3] ##1 state_reg == echo_stop_pkg::ECHO_ST;
  endproperty
  a_cancel_len: assert property (p_cancel_len) else $error("cancel length wrong"); // [RULE4]

  property p_bypass;
    @(posedge clk) disable iff (rst) ampBypass |=> ampRouteAround && !ampEnable;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not applied"); // [RULE2]

  property p_gain;
    @(posedge clk) disable iff (rst) 1'b1 |=> ampGainSel == $past(ampGainCode);
  endproperty
  a_gain: assert property (p_gain) else $error("gain code not followed"); // [RULE1]

  property p_dac;
    @(posedge clk) disable iff (rst) 1'b1 |=> $onehot(thresholdDacSel);
  endproperty
  a_dac: assert property (p_dac) else $error("dac select not one-hot"); // [RULE5]

  property p_hyst;
    @(posedge clk) disable iff (rst) (!crossAboveRef && !crossBelowHyst) |=> $stable(zeroCross_reg);
  endproperty
  a_hyst: assert property (p_hyst) else $error("zero-cross moved inside hysteresis"); // [RULE6]

  property p_no_echo_pulse;
    @(posedge clk) disable iff (rst) ev.arrivalPulse |-> $past(ev.echoActive) && $past(ev.qualified);
  endproperty
  a_no_echo_pulse: assert property (p_no_echo_pulse) else $error("pulse outside echo phase"); // [RULE8]

  property p_midrail;
    @(posedge clk) disable iff (rst) midrailBufferOff |=> !midrailBufferEnable;
  endproperty
  a_midrail: assert property (p_midrail) else $error("buffer not disabled"); // [RULE11]
endmodule
